// ===== shared/csar_pkg.sv
// Purpose: shared constants for the channel scan and alarm relay controller
// Assumes: one 25 MHz clock, registers reached over APB
// Notes:   all offsets are byte addresses of 32-bit words
package csar_pkg;
  localparam int NUM_CH         = 6;
  localparam int NUM_RLY        = 3;
  localparam int VAL_W          = 16;
  localparam int NUM_SP         = NUM_RLY * NUM_CH;
  localparam int CLK_HZ         = 25_000_000;
  localparam int SCAN_TIME_MS   = 3000;
  localparam int MANUAL_TIME_MS = 60000;
  localparam int SCAN_CYC       = SCAN_TIME_MS * (CLK_HZ / 1000);
  localparam int MANUAL_CYC     = MANUAL_TIME_MS * (CLK_HZ / 1000);
  localparam int HYST_NUM       = 9;
  localparam int HYST_DEN       = 10;
  localparam int TMR_W          = 31;

  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFS  = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS  = 12'h00C;
  localparam logic [11:0] RELAY_CLR_OFS = 12'h010;
  localparam logic [11:0] ASSIGN_OFS    = 12'h014;
  localparam logic [11:0] SETPT_OFS     = 12'h040;
  localparam logic [11:0] READING_OFS   = 12'h0C0;

  localparam int CTRL_EN_LSB    = 0;
  localparam int CTRL_LATCH_LSB = 6;
  localparam int CTRL_FDUTY_BIT = 9;
  localparam int ST_DISP_LSB    = 0;
  localparam int ST_MANUAL_BIT  = 3;
  localparam int ST_RELAY_LSB   = 4;
  localparam int ST_FAULT_LSB   = 7;
  localparam int ST_GAS_LSB     = 13;
  localparam int ST_SYSF_BIT    = 19;
  localparam int IRQ_RLY_LSB    = 0;
  localparam int IRQ_FAULT_BIT  = 3;
  localparam int IRQ_W          = 4;

  localparam logic [9:0]       CTRL_RST   = 10'h03F;
  localparam logic [17:0]      ASSIGN_RST = 18'h3FFFF;
  localparam logic [VAL_W-1:0] SETPT_RST  = 16'h0032;

  typedef enum logic [1:0] {
    SCAN_AUTO   = 2'b01,
    SCAN_MANUAL = 2'b10
  } csar_scan_e;
endpackage

// ===== rtl/csar_relay.sv
// Purpose: one alarm relay, set by threshold, released by hysteresis or clear
// Assumes: readings and set points are unsigned gas levels
// Notes:   a set point of zero leaves that channel unarmed
`timescale 1ns/100ps
module csar_relay (
  input  wire logic                                   clock,
  input  wire logic                                   arst_n,
  input  wire logic [csar_pkg::NUM_CH*csar_pkg::VAL_W-1:0] reading,
  input  wire logic [csar_pkg::NUM_CH*csar_pkg::VAL_W-1:0] setpt,
  input  wire logic [csar_pkg::NUM_CH-1:0]            chan_on,
  input  wire logic                                   latching,
  input  wire logic                                   fault_duty,
  input  wire logic                                   fault_in,
  input  wire logic                                   clear,
  output logic                                        active
);
  logic [csar_pkg::NUM_CH-1:0] trip_q;
  logic [csar_pkg::NUM_CH-1:0] trip_d;
  logic                        flt_q;
  logic                        flt_d;

  always_comb
  begin
    logic [csar_pkg::VAL_W-1:0] rd;
    logic [csar_pkg::VAL_W-1:0] sp;
    logic                       hit;
    logic                       rel;
    rd = '0;
    sp = '0;
    hit = 1'b0;
    rel = 1'b0;
    for (int c = 0; c < csar_pkg::NUM_CH; c++)
    begin
      rd = reading[c*csar_pkg::VAL_W +: csar_pkg::VAL_W];
      sp = setpt[c*csar_pkg::VAL_W +: csar_pkg::VAL_W];
      hit = (sp != '0) && (rd >= sp);
      rel = (20'(rd) * 20'(csar_pkg::HYST_DEN)) <= (20'(sp) * 20'(csar_pkg::HYST_NUM));
      // latch or auto; a new trip beats a clear
      trip_d[c] = chan_on[c] & ~fault_duty
                & (hit | (trip_q[c] & ~(latching ? clear : rel)));
    end
    flt_d = fault_duty & (fault_in | (flt_q & latching & ~clear));
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trip_q <= '0;
      flt_q  <= 1'b0;
    end
    else
    begin
      trip_q <= trip_d;
      flt_q  <= flt_d;
    end
  end

  assign active = fault_duty ? flt_q : |trip_q;
endmodule

// ===== rtl/csar_ctrl.sv
// Purpose: channel display scanning and alarm relay control, APB registers
// Assumes: sensor values, buttons and system fault are synchronous pulses/levels
// Notes:   timer counts are parameters so simulation can shorten them
// Operation
// - up to six channels, each configured fault-free channel shown in turn every 3 s
// - exactly one channel with gas holds the display on it
// - two or more gas channels rotate among themselves every 3 s
// - forward button steps to next channel, backward to previous
// - manual selection stays one minute, then automatic scan resumes
// - relay three in fault duty energizes on any monitor or channel fault
// - relay three in fault duty leaves only two relays per channel
// - each relay latches until cleared or resets by itself
// - separate set point for every relay on every channel
// - relay activates once reading reaches its threshold
// - auto relay releases at 90 percent of threshold, 10 percent band
// - triggered relay with reading below set point does not lock display
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
module csar_ctrl #(
  parameter int SCAN_CYC   = csar_pkg::SCAN_CYC,
  parameter int MANUAL_CYC = csar_pkg::MANUAL_CYC
) (
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        rx_valid,
  input  wire logic [2:0]                  rx_ch,
  input  wire logic [csar_pkg::VAL_W-1:0]  rx_value,
  input  wire logic                        rx_fault,
  input  wire logic                        sys_fault,
  input  wire logic                        btn_fwd,
  input  wire logic                        btn_back,
  output logic [2:0]                       disp_ch,
  output logic                             manual_mode,
  output logic [csar_pkg::NUM_RLY-1:0]     relay_out,
  output logic                             irq
);
  localparam int NC = csar_pkg::NUM_CH;
  localparam int NR = csar_pkg::NUM_RLY;
  localparam int VW = csar_pkg::VAL_W;
  localparam int IRQ_W_L = csar_pkg::IRQ_W;
  localparam int TMR_W_L = csar_pkg::TMR_W;

  // next or previous set bit of mask, wrapping; cur if none
  function automatic logic [2:0] step_ch(input logic [NC-1:0] mask,
                                         input logic [2:0]    cur,
                                         input logic          fwd);
    logic [2:0] res;
    logic       found;
    int         idx;
    res = cur;
    found = 1'b0;
    idx = 0;
    for (int k = 1; k <= NC; k++)
    begin
      idx = fwd ? (int'(cur) + k) % NC : (int'(cur) + NC - k) % NC;
      if (!found && mask[idx])
      begin
        res = 3'(idx);
        found = 1'b1;
      end
    end
    return res;
  endfunction

  function automatic logic single_bit(input logic [NC-1:0] m);
    return (m != '0) && ((m & (m - 1'b1)) == '0);
  endfunction

  function automatic logic [2:0] low_idx(input logic [NC-1:0] m);
    logic [2:0] res;
    res = '0;
    for (int c = NC - 1; c >= 0; c--)
    begin
      if (m[c])
      begin
        res = 3'(c);
      end
    end
    return res;
  endfunction

  // APB and configuration state
  logic [31:0]       prdata_q,  prdata_d;
  logic              pready_q,  pready_d;
  logic              pslverr_q, pslverr_d;
  logic [9:0]        ctrl_q,    ctrl_d;
  logic [17:0]       assign_q,  assign_d;
  logic [VW-1:0]     sp_q [csar_pkg::NUM_SP];
  logic [VW-1:0]     sp_d [csar_pkg::NUM_SP];
  logic [IRQ_W_L-1:0] ist_q, ist_d;
  logic [IRQ_W_L-1:0] imask_q, imask_d;
  logic [NR-1:0]     rclr_q,    rclr_d;
  logic              irq_q,     irq_d;

  // channel data
  logic [VW-1:0]     val_q [NC];
  logic [VW-1:0]     val_d [NC];
  logic [NC-1:0]     chflt_q,   chflt_d;

  // scan state
  csar_pkg::csar_scan_e scan_q, scan_d;
  logic [2:0]        disp_q,    disp_d;
  logic [csar_pkg::TMR_W-1:0] tmr_q, tmr_d;

  // relay state
  logic [NR-1:0]     relay_q,   relay_d;
  logic              fany_q,    fany_d;
  logic [NR-1:0]     rly_act;

  logic [NC-1:0]     en;
  logic [NC-1:0]     gas;
  logic [NC-1:0]     cand;
  logic              fault_any;
  logic              fduty;
  logic              setup;
  logic              wr_en;
  logic [11:0]       sp_ofs;
  logic [11:0]       rd_ofs;
  logic [4:0]        sp_idx;
  logic [2:0]        rd_idx;
  logic              sp_hit;
  logic              rd_hit;
  logic [31:0]       status;
  logic [NC*VW-1:0]  val_flat;

  assign en        = ctrl_q[csar_pkg::CTRL_EN_LSB +: NC];
  assign fduty     = ctrl_q[csar_pkg::CTRL_FDUTY_BIT];
  // gas only on good, configured channels
  assign gas       = en & ~chflt_q & {val_q[5] != '0, val_q[4] != '0, val_q[3] != '0,
                                      val_q[2] != '0, val_q[1] != '0, val_q[0] != '0};
  assign fault_any = sys_fault | |(chflt_q & en);
  assign setup     = psel & ~penable;
  assign wr_en     = psel & penable & pready_q & pwrite;
  assign sp_ofs    = paddr - csar_pkg::SETPT_OFS;
  assign rd_ofs    = paddr - csar_pkg::READING_OFS;
  assign sp_idx    = sp_ofs[6:2];
  assign rd_idx    = rd_ofs[4:2];
  assign sp_hit    = (paddr >= csar_pkg::SETPT_OFS) && (sp_ofs[1:0] == 2'b00)
                   && (int'(sp_idx) < csar_pkg::NUM_SP) && (sp_ofs[11:7] == '0);
  assign rd_hit    = (paddr >= csar_pkg::READING_OFS) && (rd_ofs[1:0] == 2'b00)
                   && (int'(rd_idx) < NC) && (rd_ofs[11:5] == '0);

  always_comb
  begin
    status = '0;
    status[csar_pkg::ST_DISP_LSB +: 3]    = disp_q;
    status[csar_pkg::ST_MANUAL_BIT]       = (scan_q == csar_pkg::SCAN_MANUAL);
    status[csar_pkg::ST_RELAY_LSB +: NR]  = relay_q;
    status[csar_pkg::ST_FAULT_LSB +: NC]  = chflt_q;
    status[csar_pkg::ST_GAS_LSB +: NC]    = gas;
    status[csar_pkg::ST_SYSF_BIT]         = sys_fault;
  end

  // APB slave: answers in the first access cycle
  always_comb
  begin
    pready_d  = setup;
    pslverr_d = 1'b0;
    prdata_d  = '0;
    if (setup)
    begin
      case (paddr)
        csar_pkg::CTRL_OFS:      prdata_d = 32'(ctrl_q);
        csar_pkg::STATUS_OFS:    prdata_d = status;
        csar_pkg::IRQ_STAT_OFS:  prdata_d = 32'(ist_q);
        csar_pkg::IRQ_MASK_OFS:  prdata_d = 32'(imask_q);
        csar_pkg::RELAY_CLR_OFS: prdata_d = '0;
        csar_pkg::ASSIGN_OFS:    prdata_d = 32'(assign_q);
        default:
        begin
          if (sp_hit)
          begin
            prdata_d = 32'(sp_q[sp_idx]);
          end
          else if (rd_hit)
          begin
            prdata_d = 32'(val_q[rd_idx]);
          end
          else
          begin
            pslverr_d = 1'b1;
          end
        end
      endcase
    end
  end

  // register writes and sticky interrupt status
  always_comb
  begin
    logic [IRQ_W_L-1:0] ev;
    ev       = '0;
    ctrl_d   = ctrl_q;
    assign_d = assign_q;
    sp_d     = sp_q;
    imask_d  = imask_q;
    rclr_d   = '0;
    ev[csar_pkg::IRQ_RLY_LSB +: NR] = rly_act & ~relay_q;
    ev[csar_pkg::IRQ_FAULT_BIT]     = fault_any & ~fany_q;
    ist_d = ist_q;
    if (wr_en)
    begin
      case (paddr)
        csar_pkg::CTRL_OFS:      ctrl_d   = pwdata[9:0];
        csar_pkg::IRQ_STAT_OFS:  ist_d    = ist_q & ~pwdata[IRQ_W_L-1:0];
        csar_pkg::IRQ_MASK_OFS:  imask_d  = pwdata[IRQ_W_L-1:0];
        csar_pkg::RELAY_CLR_OFS: rclr_d   = pwdata[NR-1:0];
        csar_pkg::ASSIGN_OFS:    assign_d = pwdata[17:0];
        default:
        begin
          // one set point per relay and channel
          if (sp_hit)
          begin
            sp_d[sp_idx] = pwdata[VW-1:0];
          end
        end
      endcase
    end
    // new events win over a write-one clear
    ist_d = ist_d | ev;
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      ctrl_q    <= csar_pkg::CTRL_RST;
      assign_q  <= csar_pkg::ASSIGN_RST;
      sp_q      <= '{default: csar_pkg::SETPT_RST};
      ist_q     <= '0;
      imask_q   <= '0;
      rclr_q    <= '0;
      irq_q     <= 1'b0;
    end
    else
    begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      ctrl_q    <= ctrl_d;
      assign_q  <= assign_d;
      sp_q      <= sp_d;
      ist_q     <= ist_d;
      imask_q   <= imask_d;
      rclr_q    <= rclr_d;
      irq_q     <= irq_d;
    end
  end

  // latest value and fault per channel
  always_comb
  begin
    val_d   = val_q;
    chflt_d = chflt_q;
    if (rx_valid && (int'(rx_ch) < NC))
    begin
      val_d[rx_ch]   = rx_value;
      chflt_d[rx_ch] = rx_fault;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      val_q   <= '{default: '0};
      chflt_q <= '0;
    end
    else
    begin
      val_q   <= val_d;
      chflt_q <= chflt_d;
    end
  end

  // display scanning
  always_comb
  begin
    // lock follows gas, never relay state
    cand   = (gas != '0) ? gas : (en & ~chflt_q);
    scan_d = scan_q;
    disp_d = disp_q;
    tmr_d  = tmr_q + 1'b1;
    if (btn_fwd || btn_back)
    begin
      scan_d = csar_pkg::SCAN_MANUAL;
      disp_d = step_ch(en, disp_q, btn_fwd);
      tmr_d  = '0;
    end
    else
    begin
      case (scan_q)
        csar_pkg::SCAN_MANUAL:
        begin
          if (tmr_q >= TMR_W_L'(MANUAL_CYC - 1))
          begin
            scan_d = csar_pkg::SCAN_AUTO;
            tmr_d  = '0;
          end
        end
        csar_pkg::SCAN_AUTO:
        begin
          // lock on a single gas channel
          if (single_bit(gas))
          begin
            disp_d = low_idx(gas);
            tmr_d  = '0;
          end
          else if (!cand[disp_q] || (tmr_q >= TMR_W_L'(SCAN_CYC - 1)))
          begin
            disp_d = step_ch(cand, disp_q, 1'b1);
            tmr_d  = '0;
          end
        end
        default:
        begin
          scan_d = csar_pkg::SCAN_AUTO;
          tmr_d  = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scan_q <= csar_pkg::SCAN_AUTO;
      disp_q <= '0;
      tmr_q  <= '0;
    end
    else
    begin
      scan_q <= scan_d;
      disp_q <= disp_d;
      tmr_q  <= tmr_d;
    end
  end

  // relays
  always_comb
  begin
    val_flat = '0;
    for (int c = 0; c < NC; c++)
    begin
      val_flat[c*VW +: VW] = val_q[c];
    end
  end

  for (genvar r = 0; r < NR; r++)
  begin : g_rly
    logic [NC*VW-1:0] sp_flat;
    for (genvar c = 0; c < NC; c++)
    begin : g_sp
      assign sp_flat[c*VW +: VW] = sp_q[r*NC + c];
    end
    csar_relay u_relay (
      .clock      (clock),
      .arst_n     (arst_n),
      .reading    (val_flat),
      .setpt      (sp_flat),
      .chan_on    (assign_q[r*NC +: NC] & en & ~chflt_q),
      .latching   (ctrl_q[csar_pkg::CTRL_LATCH_LSB + r]),
      // only the third relay takes fault duty
      .fault_duty ((r == NR - 1) ? fduty : 1'b0),
      .fault_in   (fault_any),
      .clear      (rclr_q[r]),
      .active     (rly_act[r])
    );
  end

  always_comb
  begin
    relay_d = rly_act;
    fany_d  = fault_any;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      relay_q <= '0;
      fany_q  <= 1'b0;
    end
    else
    begin
      relay_q <= relay_d;
      fany_q  <= fany_d;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign disp_ch     = disp_q;
  assign manual_mode = scan_q[1];
  assign relay_out   = relay_q;
  assign irq         = irq_q;
endmodule

// ===== tb/csar_ctrl_assertions.sv
// Purpose: port-level checks of the scan and relay controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   manual window bounds allow one cycle of skew either way
`timescale 1ns/100ps
module csar_ctrl_assertions #(
  parameter int SCAN_CYC   = 20,
  parameter int MANUAL_CYC = 100
) (
  input wire logic                         clock,
  input wire logic                         arst_n,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         rx_valid,
  input wire logic                         btn_fwd,
  input wire logic                         btn_back,
  input wire logic [2:0]                   disp_ch,
  input wire logic                         manual_mode,
  input wire logic [csar_pkg::NUM_RLY-1:0] relay_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  int man_q;
  int man_d;
  // a press restarts the manual window
  always_comb
  begin
    man_d = manual_mode ? man_q + 1 : 0;
    if (btn_fwd || btn_back)
      man_d = 0;
  end
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      man_q <= 0;
    else
      man_q <= man_d;
  end
  property p_ready_access;
    pready |-> psel && penable && $past(psel && !penable);
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("pready outside the first access cycle");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  property p_disp_range;
    disp_ch <= 3'h5;
  endproperty
  a_disp_range: assert property (p_disp_range)
    else $error("displayed channel out of range");
  property p_btn_manual;
    (btn_fwd || btn_back) |=> manual_mode;
  endproperty
  a_btn_manual: assert property (p_btn_manual)
    else $error("button press did not enter manual mode");
  property p_manual_cause;
    $rose(manual_mode) |-> $past(btn_fwd || btn_back);
  endproperty
  a_manual_cause: assert property (p_manual_cause)
    else $error("manual mode without a button press");
  property p_manual_max;
    man_q <= MANUAL_CYC + 1;
  endproperty
  a_manual_max: assert property (p_manual_max)
    else $error("manual mode held too long");
  property p_manual_end;
    $fell(manual_mode) |-> man_q >= MANUAL_CYC - 1 && man_q <= MANUAL_CYC + 1;
  endproperty
  a_manual_end: assert property (p_manual_end)
    else $error("manual mode ended early");
  property p_relay_cause;
    $rose(relay_out[0]) || $rose(relay_out[1]) |->
      $past(rx_valid, 3) || $past(psel && penable && pwrite, 3);
  endproperty
  a_relay_cause: assert property (p_relay_cause)
    else $error("alarm relay rose without a new sample or write");
endmodule
bind csar_ctrl csar_ctrl_assertions #(
  .SCAN_CYC(SCAN_CYC),
  .MANUAL_CYC(MANUAL_CYC)
) i_chk (
  .clock(clock),
  .arst_n(arst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .pslverr(pslverr),
  .rx_valid(rx_valid),
  .btn_fwd(btn_fwd),
  .btn_back(btn_back),
  .disp_ch(disp_ch),
  .manual_mode(manual_mode),
  .relay_out(relay_out)
);

// ===== tb/csar_sensor_model.sv
// Purpose: stand-in for the radio receivers that deliver channel samples
// Assumes: one sample per call, launched just after a rising edge
// Notes:   idle lines show inverted values so stale data never looks valid
`timescale 1ns/100ps
module csar_sensor_model (
  input  wire logic                       clock,
  output logic                            rx_valid,
  output logic [2:0]                      rx_ch,
  output logic [csar_pkg::VAL_W-1:0]      rx_value,
  output logic                            rx_fault
);
  initial
  begin
    rx_valid = 1'b0;
    rx_ch    = 3'h7;
    rx_value = 16'hFFFF;
    rx_fault = 1'b1;
  end
  task automatic send(input int c, input int v, input bit f);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_ch    <= c[2:0];
    rx_value <= v[15:0];
    rx_fault <= f;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_ch    <= ~c[2:0];
    rx_value <= ~v[15:0];
    rx_fault <= ~f;
  endtask
endmodule

// ===== tb/csar_ctrl_tb.sv
// Purpose: self-checking bench for the scan and relay controller
// Assumes: shortened scan and manual counts
// Notes:   relay and display expectations come from a small model
`timescale 1ns/100ps
module csar_ctrl_tb;
  localparam int SCN = 20;
  localparam int MAN = 100;
  logic        clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        sys_fault = 1'b0, btn_fwd = 1'b0, btn_back = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rx_valid, rx_fault, manual_mode, irq, rerr;
  logic [2:0]  rx_ch, disp_ch, relay_out;
  logic [15:0] rx_value;
  int          fails = 0, check_count = 0, seed = 32'h089b;
  int          rd[6], sp[18];
  bit [5:0]    flt;
  bit [2:0]    tr, lat;
  bit          fd;
  bit [17:0]   tc;
  logic [11:0] ra[5] = '{12'h000, 12'h014, 12'h040, 12'h084, 12'h00C};
  logic [31:0] rv[5] = '{32'h3F, 32'h3FFFF, 32'h32, 32'h32, 32'h0};
  int          bv[5] = '{46, 45, 50, 49, 0};
  always #20 clock = ~clock;
  csar_ctrl #(.SCAN_CYC(SCN), .MANUAL_CYC(MAN)) i_dut (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_ch(rx_ch),
    .rx_value(rx_value), .rx_fault(rx_fault), .sys_fault(sys_fault),
    .btn_fwd(btn_fwd), .btn_back(btn_back), .disp_ch(disp_ch),
    .manual_mode(manual_mode), .relay_out(relay_out), .irq(irq));
  csar_sensor_model i_sens (.clock(clock), .rx_valid(rx_valid), .rx_ch(rx_ch),
    .rx_value(rx_value), .rx_fault(rx_fault));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input bit w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk;
    repeat (3) @(posedge clock);
    chk("relay_out", relay_out, {fd ? (sys_fault | (|flt)) : tr[2], tr[1:0]});
  endtask
  // model: set at threshold, auto release at nine tenths
  task smp(input int c, input int v, input bit f);
    int x;
    i_sens.send(c, v, f);
    rd[c] = f ? 0 : v;
    flt[c] = f;
    for (int r = 0; r < 3; r++)
    begin
      for (int i = 0; i < 6; i++)
      begin
        x = r * 6 + i;
        if (sp[x] != 0 && rd[i] >= sp[x]) tc[x] = 1;
        else if (flt[i] || (!lat[r] && rd[i] * 10 <= sp[x] * 9)) tc[x] = 0;
      end
      tr[r] = |tc[r*6 +: 6];
    end
    rchk();
  endtask
  function automatic int nxt(input int cur);
    bit [5:0] g;
    for (int i = 0; i < 6; i++)
      g[i] = rd[i] > 0;
    if (g == 6'h00) g = ~flt;
    for (int i = 1; i <= 6; i++)
      if (g[(cur + i) % 6]) return (cur + i) % 6;
    return cur;
  endfunction
  task scan(input int n);
    int p;
    int t;
    for (int j = 0; j <= n; j++)
    begin
      p = disp_ch;
      t = 0;
      @(posedge clock);
      while (disp_ch === p[2:0] && t < 4 * SCN)
      begin
        @(posedge clock);
        t++;
      end
      if (j > 0) chk("scan period", t + 1, SCN);
      if (j > 0) chk("scan channel", disp_ch, nxt(p));
    end
  endtask
  task press(input bit f, input int e);
    @(posedge clock);
    btn_fwd <= f;
    btn_back <= !f;
    @(posedge clock);
    btn_fwd <= 1'b0;
    btn_back <= 1'b0;
    @(posedge clock);
    chk("step channel", disp_ch, e);
    chk("manual_mode", manual_mode, 1);
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    results();
  end
  initial
  begin
    foreach (sp[i]) sp[i] = 50;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rdat, rv[i]);
    end
    apb(1'b0, 12'h100, 32'h0);
    chk("pslverr", rerr, 1'b1);
    $display("test registers done");
    scan(6);
    smp(3, 10, 0);
    repeat (3 * SCN) @(posedge clock);
    chk("locked channel", disp_ch, 3);
    smp(1, 5, 0);
    scan(4);
    smp(1, 0, 0);
    repeat (SCN + 2) @(posedge clock);
    press(1'b1, 4);
    press(1'b0, 3);
    press(1'b0, 2);
    repeat (MAN - 10) @(posedge clock);
    chk("manual held", manual_mode, 1);
    repeat (SCN) @(posedge clock);
    chk("manual ended", manual_mode, 0);
    chk("relocked", disp_ch, 3);
    smp(3, 0, 0);
    $display("test display done");
    smp(0, 60, 0);
    apb(1'b0, 12'h008, 32'h0);
    chk("irq status", rdat, 32'h7);
    chk("irq masked", irq, 0);
    apb(1'b1, 12'h00C, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq raised", irq, 1);
    apb(1'b1, 12'h008, 32'hF);
    repeat (2) @(posedge clock);
    chk("irq cleared", irq, 0);
    foreach (bv[i]) smp(0, bv[i], 0);
    repeat (10) smp(0, $random(seed) & 32'h7F, 0);
    smp(0, 0, 0);
    $display("test relays done");
    apb(1'b1, 12'h000, 32'h07F);
    lat = 3'b001;
    smp(0, 60, 0);
    smp(0, 0, 0);
    scan(2);
    apb(1'b1, 12'h010, 32'h1);
    tc[5:0] = '0;
    tr[0] = 0;
    rchk();
    apb(1'b1, 12'h000, 32'h03F);
    lat = 3'b000;
    apb(1'b1, 12'h050, 32'd100);
    sp[4] = 100;
    apb(1'b1, 12'h068, 32'd200);
    sp[10] = 200;
    smp(4, 150, 0);
    smp(4, 0, 0);
    $display("test set points done");
    apb(1'b1, 12'h000, 32'h23F);
    fd = 1;
    smp(5, 60, 0);
    sys_fault <= 1'b1;
    rchk();
    sys_fault <= 1'b0;
    rchk();
    smp(2, 0, 1);
    smp(2, 0, 0);
    smp(5, 0, 0);
    smp(2, 0, 1);
    scan(5);
    $display("test fault duty done");
    results();
  end
endmodule
